/* card_debounce.sv */
// Debounces a synchronised card-present level.
// Input already passed a two-flop synchroniser.
`timescale 1ns/1ps
`default_nettype none
module card_debounce #(
  parameter int CYCLES = 1000000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic raw_present,
  output logic present
);
  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic present_reg;
  logic present_next;
  localparam logic [23:0] LIMIT = 24'(CYCLES);

  always_comb begin
    count_next = 24'h000000;
    present_next = present_reg;
    if (!raw_present) begin
      present_next = 1'b0;
    end else if (!present_reg) begin
      count_next = count_reg + 24'h000001;
      if (count_reg >= LIMIT) begin
        present_next = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 24'h000000;
      present_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      present_reg <= present_next;
    end
  end

  assign present = present_reg;
endmodule : card_debounce
`default_nettype wire

/* enable_low_filter.sv */
// Qualifies a falling edge of an enable whose low time reached a minimum.
// Input is already synchronised to pclk.
`timescale 1ns/1ps
`default_nettype none
module enable_low_filter #(
  parameter int MIN_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic clear_pulse
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic armed_reg;
  logic armed_next;
  localparam logic [15:0] MIN_C = 16'(MIN_CYCLES);

  always_comb begin
    count_next = count_reg;
    armed_next = armed_reg;
    clear_pulse = 1'b0;
    if (level) begin
      count_next = 16'h0000;
      armed_next = 1'b0;
    end else if (count_reg < MIN_C - 16'h0001) begin
      // Fires in the last cycle of the minimum low, so an exact-minimum pulse counts
      count_next = count_reg + 16'h0001;
    end else if (!armed_reg) begin
      // One clear per low pulse, once long enough
      clear_pulse = 1'b1;
      armed_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
      armed_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      armed_reg <= armed_next;
    end
  end
endmodule : enable_low_filter
`default_nettype wire

/* hotplug_slot_fault_control.sv */
// Two-slot hot-plug fault latching, gate enabling and power-good sequencing.
// Pins arrive asynchronously and are synchronised; APB slave on pclk.
`timescale 1ns/1ps
`default_nettype none
`include "slot_regs.svh"
module hotplug_slot_fault_control #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES,
  parameter int DELAYED_GOOD_CYCLES = `DELAYED_GOOD_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire slot_pkg::slot_vec_t main_rail_enable,
  input wire slot_pkg::slot_vec_t standby_rail_enable,
  input wire slot_pkg::slot_vec_t card_present_n,
  input wire slot_pkg::slot_vec_t force_on_n,
  input wire slot_pkg::slot_vec_t main_overcurrent,
  input wire slot_pkg::slot_vec_t main_undervoltage,
  input wire slot_pkg::slot_vec_t standby_overcurrent,
  input wire slot_pkg::slot_vec_t standby_overtemp,
  input wire slot_pkg::slot_vec_t standby_supply_ok,
  input wire slot_pkg::slot_vec_t rails_above_good,
  output slot_pkg::slot_vec_t main_gate_on,
  output slot_pkg::slot_vec_t standby_gate_on,
  output slot_pkg::slot_vec_t main_breaker_rearm,
  output slot_pkg::slot_vec_t standby_breaker_rearm,
  output slot_pkg::slot_vec_t main_fault_n_oe,
  output slot_pkg::slot_vec_t standby_fault_n_oe,
  output slot_pkg::slot_vec_t slot_power_good_n_oe,
  output slot_pkg::slot_vec_t delayed_slot_good_n_oe,
  output logic interrupt_n_oe,
  output logic system_power_ok_oe
);
  import slot_pkg::*;

  // Open-drain pins drive low only; output value is always zero
  localparam int SYNC_W = 20;
  // Active-low pins reset to their idle high level: no override and no
  // phantom card in the cycles before the synchroniser has filled
  localparam logic [SYNC_W-1:0] SYNC_IDLE = 20'h0f000;
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  slot_vec_t main_en, stby_en, present_raw, force_on, main_oc, main_uv;
  slot_vec_t stby_oc, stby_ot, stby_ok, rails_good;
  slot_vec_t card_n_sync;
  slot_vec_t force_n_sync;

  // Pins go straight into the first flop, with no logic ahead of it
  assign pins_raw = {main_rail_enable, standby_rail_enable, card_present_n, force_on_n,
    main_overcurrent, main_undervoltage, standby_overcurrent, standby_overtemp,
    standby_supply_ok, rails_above_good};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= SYNC_IDLE;
      sync2_reg <= SYNC_IDLE;
    end else begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end

  assign {main_en, stby_en, card_n_sync, force_n_sync, main_oc, main_uv, stby_oc, stby_ot,
    stby_ok, rails_good} = sync2_reg;
  assign present_raw = ~card_n_sync;
  assign force_on = ~force_n_sync;

  // Software mask of the fault interrupt and a software disable per slot
  logic [31:0] control_reg;
  logic [31:0] control_next;
  slot_vec_t sw_slot_off;
  assign sw_slot_off = control_reg[1:0];

  slot_vec_t present, main_clear, stby_clear;
  slot_vec_t main_fault_reg, main_fault_next, stby_fault_reg, stby_fault_next;
  slot_vec_t main_oc_src_reg, main_oc_src_next, stby_oc_src_reg, stby_oc_src_next;
  slot_vec_t main_en_d_reg, stby_en_d_reg, main_fall, stby_fall;
  slot_vec_t rearm_main_reg, rearm_main_next, rearm_stby_reg, rearm_stby_next;
  slot_vec_t pg_reg, pg_next, dpg_reg, dpg_next;
  good_state_t gstate_reg [2];
  good_state_t gstate_next [2];
  logic [27:0] gcount_reg [2];
  logic [27:0] gcount_next [2];
  localparam logic [27:0] DLY_C = 28'(DELAYED_GOOD_CYCLES);

  // One copy of filters, latches and sequencing per slot
  generate
    for (genvar s = 0; s < 2; s++) begin : g_slot
      card_debounce #(.CYCLES(DEBOUNCE_CYCLES)) u_deb (
        .pclk(pclk),
        .presetn(presetn),
        .raw_present(present_raw[s]),
        .present(present[s])
      );
      enable_low_filter #(.MIN_CYCLES(`MAIN_LOW_CYCLES)) u_main_lo (
        .pclk(pclk),
        .presetn(presetn),
        .level(main_en[s]),
        .clear_pulse(main_clear[s])
      );
      enable_low_filter #(.MIN_CYCLES(`STBY_LOW_CYCLES)) u_stby_lo (
        .pclk(pclk),
        .presetn(presetn),
        .level(stby_en[s]),
        .clear_pulse(stby_clear[s])
      );

      always_comb begin
        main_fault_next[s] = main_fault_reg[s];
        main_oc_src_next[s] = main_oc_src_reg[s];
        stby_fault_next[s] = stby_fault_reg[s];
        stby_oc_src_next[s] = stby_oc_src_reg[s];
        rearm_main_next[s] = 1'b0;
        rearm_stby_next[s] = 1'b0;
        // Latched fault cleared by its own enable only; a new event wins
        if (main_clear[s] && main_fault_reg[s]) begin
          main_fault_next[s] = 1'b0;
          main_oc_src_next[s] = 1'b0;
          rearm_main_next[s] = main_oc_src_reg[s];
        end
        if (stby_clear[s] && stby_fault_reg[s]) begin
          stby_fault_next[s] = 1'b0;
          stby_oc_src_next[s] = 1'b0;
          rearm_stby_next[s] = stby_oc_src_reg[s];
        end
        if (!force_on[s]) begin
          if (main_oc[s] || main_uv[s]) begin
            main_fault_next[s] = 1'b1;
          end
          if (main_oc[s]) begin
            main_oc_src_next[s] = 1'b1;
          end
          if (stby_oc[s] || stby_ot[s]) begin
            stby_fault_next[s] = 1'b1;
          end
          if (stby_oc[s]) begin
            stby_oc_src_next[s] = 1'b1;
          end
        end

        // A fault raised again in its clear cycle keeps its breaker tripped
        if (main_fault_next[s]) begin
          rearm_main_next[s] = 1'b0;
        end
        if (stby_fault_next[s]) begin
          rearm_stby_next[s] = 1'b0;
        end
      end

      // Enable falls end delayed good at once, in the same cycle as good itself
      always_comb begin
        pg_next[s] = main_en[s] && stby_en[s] && rails_good[s] && present[s]
          && !main_fault_reg[s] && !stby_fault_reg[s];
        dpg_next[s] = 1'b0;
        gstate_next[s] = gstate_reg[s];
        gcount_next[s] = gcount_reg[s];
        case (gstate_reg[s])
          good_off: begin
            gcount_next[s] = 28'h0000000;
            if (pg_reg[s]) begin
              gstate_next[s] = good_wait;
            end
          end
          good_wait: begin
            gcount_next[s] = gcount_reg[s] + 28'h0000001;
            if (!pg_reg[s] || main_fall[s] || stby_fall[s]) begin
              gstate_next[s] = good_off;
            end else if (gcount_reg[s] >= DLY_C - 28'h0000002) begin
              gstate_next[s] = good_done;
              dpg_next[s] = 1'b1;
            end
          end
          good_done: begin
            dpg_next[s] = 1'b1;
            if (!pg_reg[s] || main_fall[s] || stby_fall[s]) begin
              gstate_next[s] = good_off;
              dpg_next[s] = 1'b0;
            end
          end
          default: begin
            gstate_next[s] = good_off;
            gcount_next[s] = 28'h0000000;
          end
        endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gstate_reg[s] <= good_off;
          gcount_reg[s] <= 28'h0000000;
        end else begin
          gstate_reg[s] <= gstate_next[s];
          gcount_reg[s] <= gcount_next[s];
        end
      end

      // Gate enables: override wins, standby undervoltage lockout never defeated
      assign main_gate_on[s] = force_on[s] ||
        (main_en[s] && present[s] && !main_fault_reg[s] && !sw_slot_off[s]);
      assign standby_gate_on[s] = stby_ok[s] && (force_on[s] ||
        (stby_en[s] && present[s] && !stby_fault_reg[s] && !sw_slot_off[s]));

      // Override releases the fault pins and pulls both good pins low
      assign main_fault_n_oe[s] = main_fault_reg[s] && !force_on[s];
      assign standby_fault_n_oe[s] = stby_fault_reg[s] && !force_on[s];
      assign slot_power_good_n_oe[s] = pg_reg[s] || force_on[s];
      assign delayed_slot_good_n_oe[s] = dpg_reg[s] || force_on[s];
    end
  endgenerate

  // Edges taken from synchronised levels, never from the pins
  assign main_fall = main_en_d_reg & ~main_en;
  assign stby_fall = stby_en_d_reg & ~stby_en;

  // Fault latches, re-arm pulses and power-good state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_fault_reg <= 2'h0;
      stby_fault_reg <= 2'h0;
      main_oc_src_reg <= 2'h0;
      stby_oc_src_reg <= 2'h0;
      rearm_main_reg <= 2'h0;
      rearm_stby_reg <= 2'h0;
      main_en_d_reg <= 2'h0;
      stby_en_d_reg <= 2'h0;
      pg_reg <= 2'h0;
      dpg_reg <= 2'h0;
    end else begin
      main_fault_reg <= main_fault_next;
      stby_fault_reg <= stby_fault_next;
      main_oc_src_reg <= main_oc_src_next;
      stby_oc_src_reg <= stby_oc_src_next;
      rearm_main_reg <= rearm_main_next;
      rearm_stby_reg <= rearm_stby_next;
      main_en_d_reg <= main_en;
      stby_en_d_reg <= stby_en;
      pg_reg <= pg_next;
      dpg_reg <= dpg_next;
    end
  end

  assign main_breaker_rearm = rearm_main_reg;
  assign standby_breaker_rearm = rearm_stby_reg;

  // Interrupt released while either slot is in override
  logic int_mask;
  assign int_mask = control_reg[2];
  assign interrupt_n_oe = |(main_fault_reg | stby_fault_reg) && !(|force_on)
    && !int_mask;

  // System good pulled low while any wanted rail is not yet good and neither slot is in override
  assign system_power_ok_oe = !(|force_on)
    && |(present & (main_en | stby_en) & ~rails_good);

  // APB slave, zero wait states; read data captured in the setup
  // cycle so it stands through the whole access phase
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic [31:0] status_word;
  logic access;
  logic known;
  assign access = psel && penable;
  assign known = (paddr == `REG_CONTROL) || (paddr == `REG_STATUS);
  // Live snapshot; the source bits tell which latches re-arm on clear
  assign status_word = {16'h0000, dpg_reg, pg_reg, force_on, present, stby_fault_reg,
    main_fault_reg, stby_oc_src_reg, main_oc_src_reg};

  always_comb begin
    control_next = control_reg;
    prdata_next = prdata_reg;
    if (psel && !penable && !pwrite) begin
      case (paddr)
        `REG_CONTROL: prdata_next = control_reg;
        `REG_STATUS: prdata_next = status_word;
        default: prdata_next = 32'h00000000;
      endcase
    end
    if (access && pwrite && paddr == `REG_CONTROL) begin
      control_next = {29'h0000000, pwdata[2:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg <= `REG_CONTROL_RESET;
      prdata_reg <= 32'h00000000;
    end else begin
      control_reg <= control_next;
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = 1'b1;
  // Unmapped offsets refused in the access phase only
  assign pslverr = access && !known;
endmodule : hotplug_slot_fault_control
`default_nettype wire

/* hotplug_slot_fault_control_asserts.sv */
// Checker on slot A of the slot fault block, bound at its top.
// Assumes one pclk domain and a short debounce count in simulation.
`timescale 1ns/1ps
`default_nettype none
module hotplug_slot_fault_control_asserts #(
  parameter int DEBOUNCE_CYCLES = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire slot_pkg::slot_vec_t main_rail_enable,
  input wire slot_pkg::slot_vec_t card_present_n,
  input wire slot_pkg::slot_vec_t force_on_n,
  input wire slot_pkg::slot_vec_t main_overcurrent,
  input wire slot_pkg::slot_vec_t main_undervoltage,
  input wire slot_pkg::slot_vec_t standby_overcurrent,
  input wire slot_pkg::slot_vec_t standby_overtemp,
  input wire slot_pkg::slot_vec_t main_gate_on,
  input wire slot_pkg::slot_vec_t standby_gate_on,
  input wire slot_pkg::slot_vec_t main_breaker_rearm,
  input wire slot_pkg::slot_vec_t standby_breaker_rearm,
  input wire slot_pkg::slot_vec_t main_fault_n_oe,
  input wire slot_pkg::slot_vec_t standby_fault_n_oe,
  input wire slot_pkg::slot_vec_t slot_power_good_n_oe,
  input wire slot_pkg::slot_vec_t delayed_slot_good_n_oe,
  input wire logic interrupt_n_oe,
  input wire logic system_power_ok_oe
);
  import slot_pkg::*;
  int held_reg;
  int held_next;
  // Saturates so a long insertion never wraps
  always_comb held_next = card_present_n[0] ? 0 : held_reg + (held_reg < DEBOUNCE_CYCLES);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) held_reg <= 0;
    else held_reg <= held_next;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence forced_s; !force_on_n[0] [*4]; endsequence
  sequence main_trip_s;
    (force_on_n[0] && (main_overcurrent[0] || main_undervoltage[0])) [*5];
  endsequence
  sequence stby_trip_s;
    (force_on_n[0] && (standby_overcurrent[0] || standby_overtemp[0])) [*5];
  endsequence
  a_force_good: assert property (forced_s |->
    slot_power_good_n_oe[0] && delayed_slot_good_n_oe[0]) else $error("override good off");
  a_force_free: assert property (forced_s |->
    !(main_fault_n_oe[0] || standby_fault_n_oe[0] || interrupt_n_oe || system_power_ok_oe))
    else $error("override kept a pin low");
  a_main_trip: assert property (main_trip_s |-> main_fault_n_oe[0])
    else $error("main fault not raised");
  a_stby_trip: assert property (stby_trip_s |-> standby_fault_n_oe[0])
    else $error("standby fault not raised");
  a_main_latch: assert property ((force_on_n[0] && main_rail_enable[0]) [*6]
    ##0 main_fault_n_oe[0] |=> main_fault_n_oe[0]) else $error("main fault dropped");
  a_main_rearm: assert property ($rose(main_breaker_rearm[0]) |-> $fell(main_fault_n_oe[0]))
    else $error("main rearm off the clear");
  a_stby_rearm: assert property ($rose(standby_breaker_rearm[0]) |->
    $fell(standby_fault_n_oe[0])) else $error("standby rearm off the clear");
  a_card_off: assert property ($rose(card_present_n[0]) && force_on_n[0] |->
    ##4 !(main_gate_on[0] || standby_gate_on[0])) else $error("gates on after removal");
  a_gate_needs: assert property ((force_on_n[0] && !main_rail_enable[0]) [*5]
    |-> !main_gate_on[0]) else $error("main gate on while disabled");
  a_debounce_wait: assert property ($rose(main_gate_on[0]) && force_on_n[0] |->
    held_reg >= DEBOUNCE_CYCLES) else $error("gate on before debounce");
endmodule : hotplug_slot_fault_control_asserts
bind hotplug_slot_fault_control hotplug_slot_fault_control_asserts #(
  .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) chk_u (.*);
`default_nettype wire

/* slot_host_model.sv */
// Host model driving both slots' enables, with timed low pulses.
// Requests are one-cycle pulses on pclk; brief asks for a too-short low.
`timescale 1ns/1ps
`default_nettype none
`include "slot_regs.svh"
module slot_host_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic brief,
  input wire slot_pkg::slot_vec_t on_req,
  input wire slot_pkg::slot_vec_t aux_req,
  input wire slot_pkg::slot_vec_t main_level,
  input wire slot_pkg::slot_vec_t stby_level,
  output slot_pkg::slot_vec_t main_rail_enable,
  output slot_pkg::slot_vec_t standby_rail_enable
);
  import slot_pkg::*;
  int low_m [2];
  int low_s [2];
  // Normal low is exactly the minimum; brief is one cycle short of it
  always @(posedge pclk or negedge presetn) begin
    for (int i = 0; i < 2; i++) begin
      if (!presetn) begin
        low_m[i] <= 0;
        low_s[i] <= 0;
      end else begin
        if (on_req[i]) low_m[i] <= brief ? `MAIN_LOW_CYCLES - 1 : `MAIN_LOW_CYCLES;
        else low_m[i] <= low_m[i] - (low_m[i] != 0);
        if (aux_req[i]) low_s[i] <= brief ? `STBY_LOW_CYCLES - 1 : `STBY_LOW_CYCLES;
        else low_s[i] <= low_s[i] - (low_s[i] != 0);
      end
    end
  end
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      main_rail_enable[i] = main_level[i] && low_m[i] == 0;
      standby_rail_enable[i] = stby_level[i] && low_s[i] == 0;
    end
  end
endmodule : slot_host_model
`default_nettype wire

/* slot_pkg.sv */
// Types shared by the hot-plug slot block.
// Assumes nothing of its surroundings.
package slot_pkg;
  typedef enum logic [2:0] {
    good_off = 3'b001,
    good_wait = 3'b010,
    good_done = 3'b100
  } good_state_t;
  typedef logic [1:0] slot_vec_t;
endpackage : slot_pkg

/* slot_regs.svh */
// Constants for the dual-slot hot-plug fault and enable control block.
// Assumes a 100 MHz pclk.
`ifndef SLOT_REGS_SVH
`define SLOT_REGS_SVH
`define CLK_PERIOD_NS 10
`define MAIN_LOW_MIN_NS 200
`define STBY_LOW_MIN_NS 500
`define DEBOUNCE_MS 10
`define DELAYED_GOOD_MS 164
`define MAIN_LOW_CYCLES ((`MAIN_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STBY_LOW_CYCLES ((`STBY_LOW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * 1000000 / `CLK_PERIOD_NS)
`define DELAYED_GOOD_CYCLES (`DELAYED_GOOD_MS * 1000000 / `CLK_PERIOD_NS)
`define REG_CONTROL 12'h000
`define REG_STATUS 12'h004
`define REG_CONTROL_RESET 32'h00000000
`endif

/* test_hotplug_slot_fault_control.sv */
// Self-checking bench for the slot fault block and its host model.
// Runs the block with short debounce and delayed-good counts.
`timescale 1ns/1ps
`default_nettype none
`include "slot_regs.svh"
module test_hotplug_slot_fault_control;
  import slot_pkg::*;
  localparam int DEB = 20;
  localparam int DLY = 50;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, brief, err;
  logic interrupt_n_oe, system_power_ok_oe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  slot_vec_t main_rail_enable, standby_rail_enable, card_present_n, force_on_n;
  slot_vec_t main_overcurrent, main_undervoltage, standby_overcurrent, standby_overtemp;
  slot_vec_t standby_supply_ok, rails_above_good, main_gate_on, standby_gate_on;
  slot_vec_t main_breaker_rearm, standby_breaker_rearm, main_fault_n_oe, standby_fault_n_oe;
  slot_vec_t slot_power_good_n_oe, delayed_slot_good_n_oe, on_req, aux_req, main_level, stby_level;
  int miscompares, comparisons, seed, s, k, t0, last_rearm;
  int cycles = 0;
  hotplug_slot_fault_control #(.DEBOUNCE_CYCLES(DEB), .DELAYED_GOOD_CYCLES(DLY)) dut (.*);
  slot_host_model host (.*);
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (|(main_breaker_rearm | standby_breaker_rearm)) last_rearm <= cycles;
    if (cycles == 5000) begin
      miscompares++;
      conclude();
    end
  end
  task conclude;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : tick
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function automatic slot_vec_t bit_of(input int i);
    return slot_vec_t'(1 << i);
  endfunction : bit_of
  function automatic logic is_main(input int kind);
    return kind < 2;
  endfunction : is_main
  function automatic logic seen_fault();
    return is_main(k) ? main_fault_n_oe[s] : standby_fault_n_oe[s];
  endfunction : seen_fault
  task pulse(input logic own, input logic shrt);
    @(posedge pclk);
    brief <= shrt;
    on_req <= (is_main(k) == own) ? bit_of(s) : 2'h0;
    aux_req <= (is_main(k) != own) ? bit_of(s) : 2'h0;
    @(posedge pclk);
    on_req <= 0;
    aux_req <= 0;
    tick(`STBY_LOW_CYCLES + 12);
  endtask : pulse
  initial begin
    seed = 44242;
    {presetn, psel, penable, pwrite, paddr, pwdata, brief, last_rearm} = 0;
    {on_req, aux_req, main_level, stby_level, force_on_n, card_present_n} = 12'h00f;
    {main_overcurrent, main_undervoltage, standby_overcurrent, standby_overtemp} = 0;
    standby_supply_ok = 2'h3;
    rails_above_good = 2'h3;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    apb(0, `REG_CONTROL, 0);
    chk(rd, `REG_CONTROL_RESET);
    apb(1, 12'h008, $random(seed));
    chk(err, 1);
    $display("register test done");
    @(posedge pclk);
    {main_level, stby_level, card_present_n} <= 6'h3c;
    tick(DEB + 8);
    chk(main_gate_on & standby_gate_on, 2'h3);
    chk(slot_power_good_n_oe, 2'h3);
    tick(DLY - 10);
    chk(delayed_slot_good_n_oe, 0);
    tick(20);
    chk(delayed_slot_good_n_oe, 2'h3);
    $display("power up test done");
    for (k = 0; k < 4; k++) begin
      s = $random(seed) & 1;
      @(posedge pclk);
      case (k)
        0: main_overcurrent <= bit_of(s);
        1: main_undervoltage <= bit_of(s);
        2: standby_overcurrent <= bit_of(s);
        default: standby_overtemp <= bit_of(s);
      endcase
      tick(3 + ($random(seed) & 3));
      @(posedge pclk);
      {main_overcurrent, main_undervoltage, standby_overcurrent, standby_overtemp} <= 0;
      tick(4);
      chk(seen_fault(), 1);
      chk(is_main(k) ? standby_fault_n_oe[s] : main_fault_n_oe[s], 0);
      chk({interrupt_n_oe, slot_power_good_n_oe[s]}, 2'h2);
      pulse(1, 1);
      chk(seen_fault(), 1);
      pulse(0, 0);
      chk(seen_fault(), 1);
      t0 = cycles;
      pulse(1, 0);
      chk(seen_fault(), 0);
      chk(last_rearm > t0, k % 2 == 0);
      $display("fault test %0d done", k);
    end
    @(posedge pclk);
    card_present_n <= 2'h1;
    tick(4);
    chk(main_gate_on[0] | standby_gate_on[0], 0);
    chk(main_gate_on[1], 1);
    @(posedge pclk);
    card_present_n <= 0;
    tick(DEB - 4);
    chk(main_gate_on[0], 0);
    tick(12);
    chk(main_gate_on[0], 1);
    $display("card test done");
    apb(1, `REG_CONTROL, 32'h00000005);
    apb(0, `REG_CONTROL, 0);
    chk(rd, 32'h00000005);
    tick(1);
    chk({main_gate_on[0], standby_gate_on[0], main_gate_on[1]}, 3'h1);
    apb(0, `REG_STATUS, 0);
    chk(rd[11:0], 12'h300);
    apb(1, `REG_CONTROL, 0);
    tick(1);
    chk(main_gate_on[0] & standby_gate_on[0], 1);
    $display("control test done");
    @(posedge pclk);
    // Diagnostic override on slot A only, with faults present
    {force_on_n, main_overcurrent, main_undervoltage, standby_overtemp} <= 8'h95;
    {main_level, rails_above_good} <= 4'ha;
    tick(6);
    chk(main_gate_on[0] & standby_gate_on[0], 1);
    chk({slot_power_good_n_oe[0], delayed_slot_good_n_oe[0]}, 2'h3);
    chk({main_fault_n_oe[0], standby_fault_n_oe[0], interrupt_n_oe, system_power_ok_oe}, 0);
    @(posedge pclk);
    standby_supply_ok <= 2'h2;
    tick(5);
    chk(standby_gate_on[0], 0);
    $display("override test done");
    conclude();
  end
endmodule : test_hotplug_slot_fault_control
`default_nettype wire
